//--- hw/see_dev.sv
`timescale 1ns/1ns
`default_nettype none
module see_dev
    import see_pkg::*;
#(
    parameter int PROG_CYCLES_P = PROG_CYCLES
) (
    input  wire logic              ref_clk,    // system clock
    input  wire logic              rstn,       // sync reset, low
    see_if.dev                     bus,        // two-wire link
    input  wire logic              wp,         // write protect pin
    input  wire logic [ADDR_W-1:0] peek_addr,  // array inspect address
    output logic      [7:0]        peek_data,  // array byte, one cycle later
    output logic                   prog_busy   // programming cycle running
);

    localparam int CW = $clog2(PROG_CYCLES_P + 1);
    localparam int MEM_BYTES = PAGE_COUNT * PAGE_BYTES;

    // ----------------------------------------------------------------
    // pin synchronisers {wp, sda, scl}
    // ----------------------------------------------------------------
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync_d;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sync1  <= SYNC_RST;
            sync2  <= SYNC_RST;
            sync_d <= SYNC_RST;
        end else begin
            sync1  <= {wp, bus.sda, bus.scl};
            sync2  <= sync1;
            sync_d <= sync2;
        end
    end

    logic scl_s;
    logic sda_s;
    logic wp_s;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    assign scl_s      = sync2[0];
    assign sda_s      = sync2[1];
    assign wp_s       = sync2[2];
    assign scl_rise   = scl_s & ~sync_d[0];
    assign scl_fall   = ~scl_s & sync_d[0];
    assign start_seen = scl_s & sync_d[0] & ~sda_s & sync_d[1];
    assign stop_seen  = scl_s & sync_d[0] & sda_s & ~sync_d[1];

    // ----------------------------------------------------------------
    // protocol state
    // ----------------------------------------------------------------
    see_dev_state_e          state;
    see_dev_state_e          next_state;
    logic [3:0]              bit_cnt;
    logic [3:0]              next_bit_cnt;
    logic [7:0]              shreg;
    logic [7:0]              next_shreg;
    logic [ADDR_W-1:0]       addr;
    logic [ADDR_W-1:0]       next_addr;
    logic                    is_sn;
    logic                    next_is_sn;
    logic                    rw;
    logic                    next_rw;
    logic [PAGE_BYTES-1:0]   loaded;
    logic [PAGE_BYTES-1:0]   next_loaded;
    logic [7:0]              page_buf [PAGE_BYTES];
    logic [7:0]              next_page_buf [PAGE_BYTES];
    logic                    sda_oe_n;
    logic                    next_sda_oe_n;
    logic                    busy;
    logic                    next_busy;
    logic [CW-1:0]           prog_cnt;
    logic [CW-1:0]           next_prog_cnt;
    logic                    commit;
    logic                    next_commit;
    logic [3:0]              dev_id;

    assign dev_id = shreg[DEV_ID_MSB:DEV_ID_LSB];

    always_comb begin
        next_state    = state;
        next_bit_cnt  = bit_cnt;
        next_shreg    = shreg;
        next_addr     = addr;
        next_is_sn    = is_sn;
        next_rw       = rw;
        next_loaded   = loaded;
        next_page_buf = page_buf;
        next_sda_oe_n = sda_oe_n;
        next_busy     = busy;
        next_prog_cnt = prog_cnt;
        next_commit   = 1'b0;
        if (busy) begin
            // inputs dead until the write completes
            next_state    = SEE_IDLE;
            next_sda_oe_n = SDA_REL;
            if (prog_cnt == '0) begin
                next_busy = 1'b0;
            end else begin
                next_prog_cnt = prog_cnt - 1'b1;
            end
        end else if (start_seen) begin
            next_state    = SEE_DEVA;
            next_bit_cnt  = 4'h0;
            next_loaded   = '0;
            next_sda_oe_n = SDA_REL;
        end else if (stop_seen) begin
            next_state    = SEE_IDLE;
            next_sda_oe_n = SDA_REL;
            // protect pin looked at here only; serial block is read-only
            if (state == SEE_DATA && |loaded && !is_sn && !wp_s) begin
                next_busy     = 1'b1;
                next_prog_cnt = CW'(PROG_CYCLES_P - 1);
                next_commit   = 1'b1;
            end
        end else if (state != SEE_IDLE) begin
            if (scl_rise) begin
                if (bit_cnt < 4'h8) begin
                    next_shreg = {shreg[6:0], sda_s};
                end
                next_bit_cnt = bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
                case (state)
                    SEE_DEVA: begin
                        if (dev_id == ID_ARRAY || dev_id == ID_SERIAL) begin
                            next_sda_oe_n = 1'b0;
                            next_is_sn    = (dev_id == ID_SERIAL);
                            next_rw       = shreg[DEV_RW_BIT];
                            if (dev_id == ID_ARRAY) begin
                                next_addr[ADDR_W-1:8] = shreg[DEV_HI_MSB:DEV_HI_LSB];
                            end
                        end else begin
                            next_state = SEE_IDLE;
                        end
                    end
                    SEE_WADR: begin
                        next_sda_oe_n = 1'b0;
                        next_addr[7:0] = shreg;
                    end
                    SEE_DATA: begin
                        next_sda_oe_n            = 1'b0;
                        next_page_buf[addr[3:0]] = shreg;
                        next_loaded[addr[3:0]]   = 1'b1;
                        // wrap overwrites earlier bytes of the same page
                        next_addr[3:0] = addr[3:0] + 4'h1;
                    end
                    default: begin
                        next_state = SEE_IDLE;
                    end
                endcase
            end else if (scl_fall && bit_cnt == 4'h9) begin
                next_sda_oe_n = SDA_REL;
                next_bit_cnt  = 4'h0;
                case (state)
                    SEE_DEVA: begin
                        // read transfer not served: release after ack
                        next_state = rw ? SEE_IDLE : SEE_WADR;
                    end
                    SEE_WADR: begin
                        next_state = SEE_DATA;
                    end
                    default: begin
                        next_state = state;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state    <= SEE_IDLE;
            bit_cnt  <= 4'h0;
            shreg    <= 8'h00;
            addr     <= '0;
            is_sn    <= 1'b0;
            rw       <= 1'b0;
            loaded   <= '0;
            sda_oe_n <= SDA_REL;
            busy     <= 1'b0;
            prog_cnt <= '0;
            commit   <= 1'b0;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                page_buf[i] <= 8'h00;
            end
        end else begin
            state    <= next_state;
            bit_cnt  <= next_bit_cnt;
            shreg    <= next_shreg;
            addr     <= next_addr;
            is_sn    <= next_is_sn;
            rw       <= next_rw;
            loaded   <= next_loaded;
            sda_oe_n <= next_sda_oe_n;
            busy     <= next_busy;
            prog_cnt <= next_prog_cnt;
            commit   <= next_commit;
            page_buf <= next_page_buf;
        end
    end

    // ----------------------------------------------------------------
    // array: written in one go when programming starts
    // ----------------------------------------------------------------
    logic [7:0] mem [MEM_BYTES];

    always_ff @(posedge ref_clk) begin
        if (commit) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (loaded[i]) begin
                    mem[{addr[ADDR_W-1:4], 4'(i)}] <= page_buf[i];
                end
            end
        end
        peek_data <= mem[peek_addr];
    end

    logic sda_o_q;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sda_o_q <= 1'b0;
        end else begin
            sda_o_q <= 1'b0;
        end
    end

    assign bus.sda_dev_o    = sda_o_q;
    assign bus.sda_dev_oe_n = sda_oe_n;
    assign prog_busy        = busy;

endmodule
`default_nettype wire

//--- hw/see_host.sv
`timescale 1ns/1ns
`default_nettype none
module see_host
    import see_pkg::*;
#(
    parameter int QTR = SCL_QTR
) (
    input  wire logic       ref_clk,    // system clock
    input  wire logic       rstn,       // sync reset, low
    see_if.host             bus,        // two-wire link
    input  wire logic [3:0] reg_addr,   // command port address
    input  wire logic [7:0] reg_wdata,  // write data
    input  wire logic       reg_wr,     // write strobe
    input  wire logic       reg_rd,     // read strobe
    output logic      [7:0] reg_rdata   // read data, cycle after strobe
);

    localparam int DW = $clog2(QTR + 1);

    // ----------------------------------------------------------------
    // data line synchroniser
    // ----------------------------------------------------------------
    logic sda_m;
    logic sda_s;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            sda_m <= bus.sda;
            sda_s <= sda_m;
        end
    end

    // ----------------------------------------------------------------
    // bit sequencer, quarter-period steps of the clock it makes
    // ----------------------------------------------------------------
    see_host_op_e op;
    see_host_op_e next_op;
    logic [1:0]   qcnt;
    logic [1:0]   next_qcnt;
    logic [3:0]   bitn;
    logic [3:0]   next_bitn;
    logic [DW-1:0] div;
    logic [DW-1:0] next_div;
    logic [7:0]   txb;
    logic [7:0]   next_txb;
    logic         nack;
    logic         next_nack;
    logic         scl_q;
    logic         next_scl_q;
    logic         sda_oe_n;
    logic         next_sda_oe_n;
    logic [7:0]   rdata;
    logic [7:0]   next_rdata;
    logic         tick;

    assign tick = (div == DW'(QTR - 1));

    always_comb begin
        next_op       = op;
        next_qcnt     = qcnt;
        next_bitn     = bitn;
        next_div      = div;
        next_txb      = txb;
        next_nack     = nack;
        next_scl_q    = scl_q;
        next_sda_oe_n = sda_oe_n;
        next_rdata    = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                REG_STATUS: begin
                    next_rdata[ST_BUSY_BIT] = (op != SEE_H_IDLE);
                    next_rdata[ST_NACK_BIT] = nack;
                end
                REG_TX: begin
                    next_rdata = txb;
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
        if (op == SEE_H_IDLE) begin
            // commands during a step are dropped
            next_div  = '0;
            next_qcnt = 2'h0;
            next_bitn = 4'h0;
            if (reg_wr && reg_addr == REG_TX) begin
                next_txb = reg_wdata;
            end
            if (reg_wr && reg_addr == REG_CTRL) begin
                case (reg_wdata[1:0])
                    CMD_START: next_op = SEE_H_START;
                    CMD_STOP:  next_op = SEE_H_STOP;
                    CMD_BYTE:  next_op = SEE_H_BYTE;
                    default:   next_op = SEE_H_IDLE;
                endcase
            end
        end else begin
            next_div = tick ? '0 : div + 1'b1;
            if (tick) begin
                next_qcnt = qcnt + 2'h1;
                case (op)
                    SEE_H_START: begin
                        case (qcnt)
                            2'h0: next_sda_oe_n = SDA_REL;
                            2'h1: next_scl_q = 1'b1;
                            2'h2: next_sda_oe_n = 1'b0;
                            default: begin
                                next_scl_q = 1'b0;
                                next_op    = SEE_H_IDLE;
                            end
                        endcase
                    end
                    SEE_H_STOP: begin
                        case (qcnt)
                            2'h0: next_sda_oe_n = 1'b0;
                            2'h1: next_scl_q = 1'b1;
                            default: begin
                                next_sda_oe_n = SDA_REL;
                                next_op       = SEE_H_IDLE;
                            end
                        endcase
                    end
                    SEE_H_BYTE: begin
                        case (qcnt)
                            2'h0: begin
                                // ninth clock: let the device answer
                                next_sda_oe_n = (bitn == 4'h8) ? SDA_REL : txb[7];
                            end
                            2'h1: next_scl_q = 1'b1;
                            2'h2: begin
                                if (bitn == 4'h8) begin
                                    next_nack = sda_s;
                                end
                            end
                            default: begin
                                next_scl_q = 1'b0;
                                next_txb   = {txb[6:0], 1'b0};
                                next_bitn  = bitn + 4'h1;
                                if (bitn == 4'h8) begin
                                    next_op = SEE_H_IDLE;
                                end
                            end
                        endcase
                    end
                    default: begin
                        next_op = SEE_H_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            op       <= SEE_H_IDLE;
            qcnt     <= 2'h0;
            bitn     <= 4'h0;
            div      <= '0;
            txb      <= 8'h00;
            nack     <= 1'b0;
            scl_q    <= 1'b1;
            sda_oe_n <= SDA_REL;
            rdata    <= 8'h00;
        end else begin
            op       <= next_op;
            qcnt     <= next_qcnt;
            bitn     <= next_bitn;
            div      <= next_div;
            txb      <= next_txb;
            nack     <= next_nack;
            scl_q    <= next_scl_q;
            sda_oe_n <= next_sda_oe_n;
            rdata    <= next_rdata;
        end
    end

    logic sda_o_q;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sda_o_q <= 1'b0;
        end else begin
            sda_o_q <= 1'b0;
        end
    end

    assign bus.scl           = scl_q;
    assign bus.sda_host_o    = sda_o_q;
    assign bus.sda_host_oe_n = sda_oe_n;
    assign reg_rdata         = rdata;

endmodule
`default_nettype wire

//--- hw/see_if.sv
`timescale 1ns/1ns
`default_nettype none
interface see_if;
    logic scl;
    logic sda;
    logic sda_host_o;
    logic sda_host_oe_n;
    logic sda_dev_o;
    logic sda_dev_oe_n;

    // open-drain wire with pull-up
    assign sda = ~((~sda_host_oe_n & ~sda_host_o) | (~sda_dev_oe_n & ~sda_dev_o));

    modport dev  (input scl, input sda, output sda_dev_o, output sda_dev_oe_n);
    modport host (output scl, input sda, output sda_host_o, output sda_host_oe_n);
endinterface
`default_nettype wire

//--- hw/see_pkg.sv
package see_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS                = 100;
    localparam int SELF_TIMED_PROGRAM_TIME_US   = 5000;
    // longest time, so round down
    localparam int PROG_CYCLES = (SELF_TIMED_PROGRAM_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int SCL_QTR     = 4;

    // ----------------------------------------------------------------
    // array geometry and address byte fields
    // ----------------------------------------------------------------
    localparam int         PAGE_BYTES   = 16;
    localparam int         PAGE_COUNT   = 128;
    localparam int         ADDR_W       = 11;
    localparam int         DEV_ID_MSB   = 7;
    localparam int         DEV_ID_LSB   = 4;
    localparam int         DEV_HI_MSB   = 3;
    localparam int         DEV_HI_LSB   = 1;
    localparam int         DEV_RW_BIT   = 0;
    localparam logic [3:0] ID_ARRAY     = 4'ha;
    localparam logic [3:0] ID_SERIAL    = 4'hb;
    localparam logic [1:0] SN_WORD_TAG  = 2'h2;

    // ----------------------------------------------------------------
    // host command port
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_TX       = 4'h1;
    localparam logic [3:0] REG_STATUS   = 4'h2;
    localparam logic [1:0] CMD_START    = 2'h1;
    localparam logic [1:0] CMD_STOP     = 2'h2;
    localparam logic [1:0] CMD_BYTE     = 2'h3;
    localparam int         ST_BUSY_BIT  = 0;
    localparam int         ST_NACK_BIT  = 1;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] SYNC_RST     = 3'h3;
    localparam logic       SDA_REL      = 1'h1;

    typedef enum logic [2:0] {
        SEE_IDLE = 3'h0,
        SEE_DEVA = 3'h1,
        SEE_WADR = 3'h2,
        SEE_DATA = 3'h3
    } see_dev_state_e;

    typedef enum logic [1:0] {
        SEE_H_IDLE  = 2'h0,
        SEE_H_START = 2'h1,
        SEE_H_STOP  = 2'h2,
        SEE_H_BYTE  = 2'h3
    } see_host_op_e;

endpackage

//--- sim/see_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module see_assertions #(
    parameter int PROG_P = 200
) (
    input wire logic ref_clk,      // system clock
    input wire logic rstn,         // sync reset, low
    input wire logic scl,          // link clock
    input wire logic sda,          // resolved data wire
    input wire logic sda_dev_oe_n, // device drive enable, low
    input wire logic wp,           // protect pin
    input wire logic prog_busy     // programming running
);
    logic       scl_q;
    logic       sda_q;
    logic [3:0] since_stop;
    logic [3:0] next_since_stop;
    logic [15:0] busy_cnt;
    logic [15:0] next_busy_cnt;
    // ----------------------------------------------------------------
    // helper counters
    // ----------------------------------------------------------------
    always_comb begin
        next_since_stop = (since_stop == 4'hf) ? since_stop : since_stop + 4'h1;
        if (scl && scl_q && sda && !sda_q) begin
            next_since_stop = 4'h0;
        end
        next_busy_cnt = prog_busy ? busy_cnt + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge ref_clk) begin
        scl_q      <= rstn ? scl : 1'b1;
        sda_q      <= rstn ? sda : 1'b1;
        since_stop <= rstn ? next_since_stop : 4'hf;
        busy_cnt   <= rstn ? next_busy_cnt : 16'h0000;
    end
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    busy_no_ack_a: assert property (prog_busy |-> sda_dev_oe_n)
        else $error("device drives data while programming");
    prog_after_stop_a: assert property ($rose(prog_busy) |-> since_stop <= 4'h8)
        else $error("programming began without a recent stop");
    prog_length_a: assert property ($fell(prog_busy) |-> busy_cnt == PROG_P)
        else $error("programming cycle has wrong length");
    wp_blocks_a: assert property ($rose(prog_busy) |-> !$past(wp, 3))
        else $error("programming began under write protect");
    dev_edge_low_a: assert property ($changed(sda_dev_oe_n) |-> !scl)
        else $error("device data changed with clock high");
    dev_stable_high_a: assert property (scl && $past(scl) |-> $stable(sda_dev_oe_n))
        else $error("device data moved during clock high");
    ack_hold_a: assert property ($fell(sda_dev_oe_n) |=> !sda_dev_oe_n [*8])
        else $error("acknowledge released too early");
    scl_high_time_a: assert property ($rose(scl) |-> scl [*7])
        else $error("link clock high phase too short");
    cover property ($rose(prog_busy));
    cover property ($fell(sda_dev_oe_n));
    cover property (wp && since_stop == 4'h2);
endmodule
`default_nettype wire

//--- sim/serial_eeprom_addr_write_test.sv
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_addr_write_test;
    import see_pkg::*;
    localparam int PROG_P = 200;
    logic              ref_clk = 1'b0;
    logic              rstn = 1'b0;
    logic              wp = 1'b0;
    logic [ADDR_W-1:0] peek_addr = '0;
    logic [7:0]        peek_data;
    logic              prog_busy;
    logic [3:0]        reg_addr = 4'h0;
    logic [7:0]        reg_wdata = 8'h00;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [7:0]        reg_rdata;
    int                num_errors = 0;
    int                tests_run = 0;
    see_if bus_if ();
    see_dev #(.PROG_CYCLES_P(PROG_P)) i_see_dev (.ref_clk(ref_clk), .rstn(rstn), .bus(bus_if),
        .wp(wp), .peek_addr(peek_addr), .peek_data(peek_data), .prog_busy(prog_busy));
    see_host i_see_host (.ref_clk(ref_clk), .rstn(rstn), .bus(bus_if), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    see_assertions #(.PROG_P(PROG_P)) i_see_assertions (.ref_clk(ref_clk), .rstn(rstn),
        .scl(bus_if.scl), .sda(bus_if.sda), .sda_dev_oe_n(bus_if.sda_dev_oe_n), .wp(wp),
        .prog_busy(prog_busy));
    always #50 ref_clk = ~ref_clk;
    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic timeout;
        num_errors++;
        complete_run();
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // one command, then poll until the host step ends
    task automatic cmd(input logic [1:0] op, output logic [7:0] st);
        int n;
        n = 0;
        wr(REG_CTRL, {6'h00, op});
        st = 8'h01;
        while (st[ST_BUSY_BIT] !== 1'b0) begin
            if (n == 400) timeout();
            rd(REG_STATUS, st);
            n++;
        end
    endtask
    task automatic sb(input logic [7:0] b, input logic nack);
        logic [7:0] st;
        wr(REG_TX, b);
        rd(REG_TX, st);
        check("tx byte", st, b);
        cmd(CMD_BYTE, st);
        check("ack bit", {7'h00, st[ST_NACK_BIT]}, {7'h00, nack});
    endtask
    task automatic go(input logic [1:0] op);
        logic [7:0] st;
        cmd(op, st);
    endtask
    task automatic busy_after_stop(input logic exp);
        // fixed wait: the stop must clear the device's synchronisers first
        repeat (8) @(posedge ref_clk);
        #1 check("prog_busy", {7'h00, prog_busy}, {7'h00, exp});
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        while (prog_busy !== 1'b0) begin
            if (n == 600) timeout();
            @(posedge ref_clk);
            n++;
        end
    endtask
    task automatic peek(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        peek_addr <= a;
        repeat (2) @(posedge ref_clk);
        #1 check("array byte", peek_data, exp);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        // byte write to 0x53c, poll while busy, wp flips mid-cycle
        go(CMD_START);
        sb(8'haa, 1'b0);
        sb(8'h3c, 1'b0);
        sb(8'ha5, 1'b0);
        go(CMD_STOP);
        busy_after_stop(1'b1);
        @(posedge ref_clk) wp <= 1'b1;
        go(CMD_START);
        sb(8'haa, 1'b1);
        go(CMD_STOP);
        wait_done();
        peek(11'h53c, 8'ha5);
        peek(11'h53c, 8'ha5);
        // protected write: acked, nothing programmed, ready at once
        go(CMD_START);
        sb(8'haa, 1'b0);
        sb(8'h3c, 1'b0);
        sb(8'h5a, 1'b0);
        go(CMD_STOP);
        busy_after_stop(1'b0);
        go(CMD_START);
        sb(8'haa, 1'b0);
        go(CMD_STOP);
        peek(11'h53c, 8'ha5);
        @(posedge ref_clk) wp <= 1'b0;
        // foreign id, serial region, read select
        go(CMD_START);
        sb(8'h90, 1'b1);
        go(CMD_START);
        sb(8'hb0, 1'b0);
        sb(8'h80, 1'b0);
        go(CMD_START);
        sb(8'ha1, 1'b0);
        go(CMD_STOP);
        // page write crossing the page end wraps to its start
        go(CMD_START);
        sb(8'ha0, 1'b0);
        sb(8'h0e, 1'b0);
        for (int i = 1; i <= 3; i++) begin
            sb(8'(i * 8'h11), 1'b0);
        end
        go(CMD_STOP);
        busy_after_stop(1'b1);
        wait_done();
        peek(11'h00e, 8'h11);
        peek(11'h00f, 8'h22);
        peek(11'h000, 8'h33);
        complete_run();
    end
endmodule
`default_nettype wire
